// File: inc/cp_pkg.sv
// Purpose: constants and types for the manual call progress block
// Assumes: AHB-Lite register access, 25 MHz clk
// Notes:
package cp_pkg;
  localparam logic [7:0] A_SELECT   = 8'h00;
  localparam logic [7:0] A_LOW      = 8'h04;
  localparam logic [7:0] A_HIGH     = 8'h08;
  localparam logic [7:0] A_DIALWAIT = 8'h0C;
  localparam logic [7:0] A_COMMAND  = 8'h10;
  localparam logic [7:0] A_STATE    = 8'h14;
  localparam logic [7:0] A_IRQ_STAT = 8'h18;
  localparam logic [7:0] A_IRQ_MASK = 8'h1C;
  localparam logic [7:0] A_BUSY_CAD = 8'h20;
  localparam logic [7:0] A_RING_CAD = 8'h24;
  localparam logic [7:0] SEL_ADDR   = 8'h00;
  localparam logic [7:0] SEL_DATA   = 8'h01;
  localparam logic [7:0] SEL_TONE   = 8'h02;
  localparam logic [2:0] CMD_DIAL_SEMI  = 3'h1;
  localparam logic [2:0] CMD_DIAL_NUM   = 3'h2;
  localparam logic [2:0] CMD_DIAL_PLAIN = 3'h3;
  localparam logic [2:0] CMD_HANGUP     = 3'h4;
  localparam logic [2:0] TONE_OFF  = 3'h0;
  localparam logic [2:0] TONE_DTMF = 3'h1;
  localparam logic [2:0] TONE_USER = 3'h6;
  localparam logic [15:0] IND_USER_FREQ   = 16'h0005;
  localparam logic [15:0] IND_CENTER_1    = 16'h0007;
  localparam logic [15:0] IND_GEN_LEVEL   = 16'h000B;
  localparam logic [15:0] IND_SENSITIVITY = 16'h000E;
  localparam logic [13:0] USER_FREQ_RST   = 14'h005B;
  localparam logic [13:0] GEN_LEVEL_RST   = 14'h0B50;
  localparam logic [13:0] SENSITIVITY_RST = 14'h1000;
  localparam logic [13:0] CENTER_RST_A    = 14'h137B;
  localparam logic [13:0] CENTER_RST_B    = 14'h0218;
  localparam logic [7:0] RING_ON_RST    = 8'h25;
  localparam logic [7:0] RING_OFF_RST   = 8'h4B;
  localparam logic [7:0] RING_DELTA_RST = 8'h08;
  localparam logic [7:0] BUSY_ON_RST    = 8'h32;
  localparam logic [7:0] BUSY_OFF_RST   = 8'h32;
  localparam logic [7:0] BUSY_DELTA_RST = 8'h05;
  localparam int CLK_KHZ      = 25000;
  localparam int BUSY_UNIT_US = 10000;
  localparam int RING_UNIT_NS = 53333333;
  localparam int BUSY_UNIT_CYC = BUSY_UNIT_US * CLK_KHZ / 1000;
  localparam int RING_UNIT_CYC = int'(64'(RING_UNIT_NS) * CLK_KHZ / 1000000000);
  localparam int IRQ_TONE = 0;
  localparam int IRQ_DIAL = 1;
  localparam int IRQ_AVAIL = 2;
  localparam int N_CLASS = 5;
  typedef enum logic [1:0] {
    ST_ONHOOK  = 2'b00,
    ST_DIALING = 2'b01,
    ST_OFFCMD  = 2'b10,
    ST_ANSWER  = 2'b11
  } call_state_t;
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } bus_req_t;
  typedef struct packed {
    logic       avail;
    logic       detected;
    logic       reserved;
    logic [4:0] kind;
  } tone_status_t;
endpackage

// File: hw/dtmf_table.sv
// Purpose: DTMF code to key and tone-pair lookup
// Assumes: code is the 4-bit transmit field
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module dtmf_table
  import cp_pkg::*;
(
  input  wire logic [3:0]  code,
  output logic      [7:0]  key,
  output logic      [10:0] low_hz,
  output logic      [10:0] high_hz
);
  assign key = (code < 4'hA) ? (8'h30 + {4'h0, code}) :
               (code == 4'hA) ? 8'h44 : (code == 4'hB) ? 8'h2A :
               (code == 4'hC) ? 8'h23 : (code == 4'hD) ? 8'h41 :
               (code == 4'hE) ? 8'h42 : 8'h43;
  always_comb
  begin
    case (code)
      4'h1, 4'h2, 4'h3, 4'hD: low_hz = 11'd697;
      4'h4, 4'h5, 4'h6, 4'hE: low_hz = 11'd770;
      4'h7, 4'h8, 4'h9, 4'hF: low_hz = 11'd852;
      default:                low_hz = 11'd941;
    endcase
    case (code)
      4'h1, 4'h4, 4'h7, 4'hB: high_hz = 11'd1209;
      4'h0, 4'h2, 4'h5, 4'h8: high_hz = 11'd1336;
      4'h3, 4'h6, 4'h9, 4'hC: high_hz = 11'd1477;
      default:                high_hz = 11'd1633;
    endcase
  end
endmodule
`default_nettype wire

// File: hw/tone_priority.sv
// Purpose: priority encoder for detected tone classes
// Assumes: class 0 DTMF, 1 answer, 2 V.23, 3 user 1/2, 4 user 3/4
// Notes: answer tone outranks everything
`timescale 1ns/1ps
`default_nettype none
module tone_priority
  import cp_pkg::*;
(
  input  wire logic [N_CLASS-1:0] present,
  input  wire logic [N_CLASS-1:0] enable,
  output logic                    detected,
  output logic      [4:0]         kind
);
  logic [N_CLASS-1:0] live;
  // disabled classes never reach the encoder
  assign live = present & enable;
  assign detected = |live;
  assign kind = live[1] ? 5'h02 : live[2] ? 5'h03 : live[3] ? 5'h04 :
                live[4] ? 5'h05 : live[0] ? 5'h01 : 5'h00;
endmodule
`default_nettype wire

// File: hw/call_progress_ctrl.sv
// Purpose: manual call progress control with AHB-Lite registers
// Assumes: single clock, synchronous inputs, zero-wait slave
// Notes: indirect port modelled as low/high/select registers
//
// Implementation choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module call_progress_ctrl
  import cp_pkg::*;
#(
  parameter int BUSY_CYC = BUSY_UNIT_CYC,
  parameter int RING_CYC = RING_UNIT_CYC
)
(
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic      [31:0]        hrdata,
  output logic                    hresp,
  input  wire logic [N_CLASS-1:0] class_present,
  input  wire logic [55:0]        udf_energy,
  input  wire logic               data_avail,
  input  wire logic               dial_done,
  output logic                    irq,
  output logic                    off_hook,
  output logic                    command_mode,
  output logic                    dial_start,
  output logic                    answer_search,
  output logic      [2:0]         gen_tone,
  output logic      [13:0]        gen_level,
  output logic      [13:0]        gen_user_freq,
  output logic      [7:0]         gen_key,
  output logic      [10:0]        gen_low_hz,
  output logic      [10:0]        gen_high_hz,
  output logic                    filt_wr,
  output logic      [15:0]        filt_addr,
  output logic      [13:0]        filt_data,
  output logic      [55:0]        udf_centers,
  output logic                    busy_tick,
  output logic                    ring_tick
);
  bus_req_t     req_ff;
  call_state_t  state_ff;
  call_state_t  nxt_state;
  tone_status_t status_w;
  logic [7:0]   select_ff;
  logic [7:0]   low_wr_ff;
  logic [7:0]   report_en_ff;
  logic [15:0]  dsp_addr_ff;
  logic [7:0]   dsp_hi_ff;
  logic [7:0]   dial_wait_ff;
  logic [13:0]  sensitivity_ff;
  logic [13:0]  user_freq_ff;
  logic [13:0]  gen_level_ff;
  logic [23:0]  busy_cad_ff;
  logic [23:0]  ring_cad_ff;
  logic [2:0]   irq_stat_ff;
  logic [2:0]   irq_mask_ff;
  logic [31:0]  busy_cnt_ff;
  logic [31:0]  ring_cnt_ff;
  logic         tone_prev_ff;
  logic         avail_prev_ff;
  logic [3:0]   udf_hit;
  logic         tone_det;
  logic [4:0]   tone_kind;
  logic [7:0]   key_w;
  logic [10:0]  low_w;
  logic [10:0]  high_w;
  logic [31:0]  rdata_w;
  logic [2:0]   irq_set;
  logic [2:0]   irq_clr;
  logic [N_CLASS-1:0] class_w;
  logic [N_CLASS-1:0] enable_w;

  function automatic logic hit(input bus_req_t r, input logic [7:0] a);
    hit = r.valid && r.write && (r.addr == a);
  endfunction

  wire addr_phase = hsel && hready && htrans[1];
  wire rd_phase   = addr_phase && !hwrite;
  wire wr_sel     = hit(req_ff, A_SELECT);
  wire wr_low     = hit(req_ff, A_LOW);
  wire wr_high    = hit(req_ff, A_HIGH);
  wire wr_cmd     = hit(req_ff, A_COMMAND);
  wire [2:0] cmd  = hwdata[2:0];
  wire tone_sel   = (select_ff == SEL_TONE);
  // indirect data writes only stick on-hook in command mode
  wire dsp_ok     = (state_ff == ST_ONHOOK);
  wire data_wr    = wr_low && (select_ff == SEL_DATA) && dsp_ok;
  wire [13:0] dsp_word = {dsp_hi_ff[5:0], hwdata[7:0]};
  wire rd_stat    = rd_phase && (haddr[7:0] == A_IRQ_STAT);

  // shared threshold across the four detectors
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_udf
      logic [13:0] center_ff;
      wire [15:0] my_addr = IND_CENTER_1 + 16'(gi);
      assign udf_hit[gi] = udf_energy[gi*14 +: 14] >= sensitivity_ff;
      assign udf_centers[gi*14 +: 14] = center_ff;
      always_ff @(posedge clk)
      begin
        if (rst)
          center_ff <= (gi % 2 == 0) ? CENTER_RST_A : CENTER_RST_B;
        else if (data_wr && dsp_addr_ff == my_addr)
          center_ff <= dsp_word;
      end
    end
  endgenerate

  assign class_w  = {class_present[4] | udf_hit[3] | udf_hit[2],
                     class_present[3] | udf_hit[1] | udf_hit[0],
                     class_present[2:0]};
  assign enable_w = report_en_ff[4:0];

  tone_priority u_prio (
    .present  (class_w),
    .enable   (enable_w),
    .detected (tone_det),
    .kind     (tone_kind)
  );

  assign status_w.avail    = data_avail;
  assign status_w.detected = tone_det;
  assign status_w.reserved = 1'b0;
  assign status_w.kind     = tone_kind;

  dtmf_table u_dtmf (
    .code    (low_wr_ff[6:3]),
    .key     (key_w),
    .low_hz  (low_w),
    .high_hz (high_w)
  );

  // read data captured in the address phase so hrdata is a flop
  always_comb
  begin
    rdata_w = 32'h0000_0000;
    case (haddr[7:0])
      A_SELECT:   rdata_w[7:0] = select_ff;
      // selector 0x2 read returns the encoded report
      A_LOW:      rdata_w[7:0] = tone_sel ? status_w : 8'h00;
      A_DIALWAIT: rdata_w[7:0] = dial_wait_ff;
      A_STATE:    rdata_w[1:0] = state_ff;
      A_IRQ_STAT: rdata_w[2:0] = irq_stat_ff;
      A_IRQ_MASK: rdata_w[2:0] = irq_mask_ff;
      A_BUSY_CAD: rdata_w[23:0] = busy_cad_ff;
      A_RING_CAD: rdata_w[23:0] = ring_cad_ff;
      default:    rdata_w = 32'h0000_0000;
    endcase
  end

  // call sequencing
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_ONHOOK, ST_OFFCMD:
      begin
        // no number, just off-hook in command mode
        if (wr_cmd && cmd == CMD_DIAL_SEMI)
          nxt_state = ST_OFFCMD;
        // blind dial right away, no dial-tone wait
        else if (wr_cmd && cmd == CMD_DIAL_NUM)
          nxt_state = ST_DIALING;
        // plain dial hunts for answer tone
        else if (wr_cmd && cmd == CMD_DIAL_PLAIN)
          nxt_state = ST_ANSWER;
        else if (wr_cmd && cmd == CMD_HANGUP)
          nxt_state = ST_ONHOOK;
      end
      ST_DIALING:
      begin
        // back to command mode once digits are out
        if (dial_done)
          nxt_state = ST_OFFCMD;
      end
      ST_ANSWER:
      begin
        if (wr_cmd && cmd == CMD_HANGUP)
          nxt_state = ST_ONHOOK;
      end
      default: nxt_state = ST_ONHOOK;
    endcase
  end

  assign irq_set = {data_avail & ~avail_prev_ff,
                    (state_ff == ST_DIALING) & dial_done,
                    tone_det & ~tone_prev_ff};
  assign irq_clr = rd_stat ? 3'h7 : 3'h0;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      req_ff    <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end
    else
    begin
      req_ff    <= '{addr_phase, hwrite, haddr[7:0]};
      hrdata    <= rd_phase ? rdata_w : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      select_ff    <= SEL_ADDR;
      low_wr_ff    <= 8'h00;
      report_en_ff <= 8'h00;
      dial_wait_ff <= 8'h00;
      dsp_addr_ff  <= 16'h0000;
      dsp_hi_ff    <= 8'h00;
    end
    else
    begin
      if (wr_sel)
        select_ff <= hwdata[7:0];
      if (wr_low && select_ff == SEL_ADDR)
        dsp_addr_ff[7:0] <= hwdata[7:0];
      if (wr_high && select_ff == SEL_ADDR)
        dsp_addr_ff[15:8] <= hwdata[7:0];
      if (wr_high && select_ff == SEL_DATA)
        dsp_hi_ff <= hwdata[7:0];
      // host writes transmit control then report enables
      if (wr_low && tone_sel)
        low_wr_ff <= hwdata[7:0];
      if (wr_high && tone_sel)
        report_en_ff <= hwdata[7:0];
      if (hit(req_ff, A_DIALWAIT))
        dial_wait_ff <= hwdata[7:0];
    end
  end

  // threshold and generator parameters through the data port
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sensitivity_ff <= SENSITIVITY_RST;
      user_freq_ff   <= USER_FREQ_RST;
      gen_level_ff   <= GEN_LEVEL_RST;
    end
    else if (data_wr)
    begin
      if (dsp_addr_ff == IND_SENSITIVITY)
        sensitivity_ff <= dsp_word;
      if (dsp_addr_ff == IND_USER_FREQ)
        user_freq_ff <= dsp_word;
      if (dsp_addr_ff == IND_GEN_LEVEL)
        gen_level_ff <= dsp_word;
    end
  end

  // every on-hook data write is forwarded to the filter bank
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      filt_wr   <= 1'b0;
      filt_addr <= 16'h0000;
      filt_data <= 14'h0000;
    end
    else
    begin
      filt_wr <= data_wr;
      if (data_wr)
      begin
        filt_addr <= dsp_addr_ff;
        filt_data <= dsp_word;
      end
    end
  end

  // national cadence defaults, host may overwrite
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      busy_cad_ff <= {BUSY_DELTA_RST, BUSY_OFF_RST, BUSY_ON_RST};
      ring_cad_ff <= {RING_DELTA_RST, RING_OFF_RST, RING_ON_RST};
    end
    else
    begin
      if (hit(req_ff, A_BUSY_CAD))
        busy_cad_ff <= hwdata[23:0];
      if (hit(req_ff, A_RING_CAD))
        ring_cad_ff <= hwdata[23:0];
    end
  end

  // cadence unit ticks for busy and ringback timing
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      busy_cnt_ff <= 32'h0000_0000;
      ring_cnt_ff <= 32'h0000_0000;
      busy_tick   <= 1'b0;
      ring_tick   <= 1'b0;
    end
    else
    begin
      busy_tick   <= (busy_cnt_ff == 32'(BUSY_CYC - 1));
      ring_tick   <= (ring_cnt_ff == 32'(RING_CYC - 1));
      busy_cnt_ff <= (busy_cnt_ff == 32'(BUSY_CYC - 1)) ? 32'h0 : busy_cnt_ff + 32'h1;
      ring_cnt_ff <= (ring_cnt_ff == 32'(RING_CYC - 1)) ? 32'h0 : ring_cnt_ff + 32'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_ff      <= ST_ONHOOK;
      off_hook      <= 1'b0;
      command_mode  <= 1'b1;
      dial_start    <= 1'b0;
      answer_search <= 1'b0;
    end
    else
    begin
      state_ff      <= nxt_state;
      off_hook      <= (nxt_state != ST_ONHOOK);
      command_mode  <= (nxt_state == ST_ONHOOK) || (nxt_state == ST_OFFCMD);
      dial_start    <= (nxt_state == ST_DIALING) && (state_ff != ST_DIALING);
      answer_search <= (nxt_state == ST_ANSWER);
    end
  end

  // tone generator follows the transmit field
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      gen_tone      <= TONE_OFF;
      gen_level     <= 14'h0000;
      gen_user_freq <= 14'h0000;
      gen_key       <= 8'h00;
      gen_low_hz    <= 11'h000;
      gen_high_hz   <= 11'h000;
    end
    else
    begin
      gen_tone      <= low_wr_ff[2:0];
      gen_level     <= (low_wr_ff[2:0] == TONE_USER) ? gen_level_ff : 14'h0000;
      gen_user_freq <= (low_wr_ff[2:0] == TONE_USER) ? user_freq_ff : 14'h0000;
      gen_key       <= key_w;
      gen_low_hz    <= (low_wr_ff[2:0] == TONE_DTMF) ? low_w : 11'h000;
      gen_high_hz   <= (low_wr_ff[2:0] == TONE_DTMF) ? high_w : 11'h000;
    end
  end

  // set beats the read-clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irq_stat_ff   <= 3'h0;
      irq_mask_ff   <= 3'h0;
      irq           <= 1'b0;
      tone_prev_ff  <= 1'b0;
      avail_prev_ff <= 1'b0;
    end
    else
    begin
      irq_stat_ff   <= (irq_stat_ff & ~irq_clr) | irq_set;
      if (hit(req_ff, A_IRQ_MASK))
        irq_mask_ff <= hwdata[2:0];
      irq           <= |(((irq_stat_ff & ~irq_clr) | irq_set) & irq_mask_ff);
      tone_prev_ff  <= tone_det;
      avail_prev_ff <= data_avail;
    end
  end
endmodule
`default_nettype wire

// File: testbench/cp_chk.sv
// Purpose: port checker for call_progress_ctrl
// Assumes: one clock, synchronous active-high rst
// Notes: tick counters restart at every reset
`timescale 1ns/1ps
`default_nettype none
module cp_chk
  import cp_pkg::*;
#(
  parameter int BUSY_CYC = 10,
  parameter int RING_CYC = 20
)
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [31:0] hrdata,
  input wire logic        irq,
  input wire logic        off_hook,
  input wire logic        command_mode,
  input wire logic        dial_start,
  input wire logic        answer_search,
  input wire logic [2:0]  gen_tone,
  input wire logic [13:0] gen_level,
  input wire logic [13:0] gen_user_freq,
  input wire logic [10:0] gen_low_hz,
  input wire logic [10:0] gen_high_hz,
  input wire logic        filt_wr,
  input wire logic        busy_tick,
  input wire logic        ring_tick
);
  logic [31:0] busy_cnt_ff;
  logic [31:0] ring_cnt_ff;
  logic        busy_seen_ff;
  logic        ring_seen_ff;
  // first tick after reset has no reference point
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      busy_cnt_ff  <= '0;
      ring_cnt_ff  <= '0;
      busy_seen_ff <= 1'b0;
      ring_seen_ff <= 1'b0;
    end
    else
    begin
      busy_cnt_ff  <= busy_tick ? '0 : busy_cnt_ff + 32'h1;
      ring_cnt_ff  <= ring_tick ? '0 : ring_cnt_ff + 32'h1;
      busy_seen_ff <= busy_seen_ff | busy_tick;
      ring_seen_ff <= ring_seen_ff | ring_tick;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_reset_idle:
    assert property ($fell(rst) |-> !off_hook && command_mode && !irq && hrdata == '0)
    else $error("idle outputs wrong after reset");
  a_busy_period:
    assert property (busy_seen_ff |-> busy_tick == (busy_cnt_ff == BUSY_CYC - 1))
    else $error("busy tick spacing wrong");
  a_ring_period:
    assert property (ring_seen_ff |-> ring_tick == (ring_cnt_ff == RING_CYC - 1))
    else $error("ringback tick spacing wrong");
  a_dial_pulse:
    assert property (dial_start |-> off_hook ##1 !dial_start)
    else $error("dial start not a single off-hook pulse");
  a_answer_hook:
    assert property (answer_search |-> off_hook)
    else $error("answer search while on-hook");
  a_user_gated:
    assert property (gen_tone != TONE_USER |-> gen_level == '0 && gen_user_freq == '0)
    else $error("user tone outputs active for other code");
  a_dtmf_pair:
    assert property (gen_tone == TONE_DTMF |-> gen_low_hz inside {697, 770, 852, 941}
      && gen_high_hz inside {1209, 1336, 1477, 1633})
    else $error("dtmf pair outside keypad groups");
  a_dtmf_gated:
    assert property (gen_tone != TONE_DTMF |-> gen_low_hz == '0 && gen_high_hz == '0)
    else $error("dtmf pair active for other code");
  a_filt_onhook:
    assert property (filt_wr |-> !off_hook ##1 !filt_wr)
    else $error("filter write off-hook or too long");
endmodule
bind call_progress_ctrl cp_chk #(.BUSY_CYC(BUSY_CYC), .RING_CYC(RING_CYC)) i_cp_chk (
  .clk(clk), .rst(rst), .hrdata(hrdata), .irq(irq), .off_hook(off_hook),
  .command_mode(command_mode), .dial_start(dial_start), .answer_search(answer_search),
  .gen_tone(gen_tone), .gen_level(gen_level), .gen_user_freq(gen_user_freq),
  .gen_low_hz(gen_low_hz), .gen_high_hz(gen_high_hz), .filt_wr(filt_wr),
  .busy_tick(busy_tick), .ring_tick(ring_tick)
);
`default_nettype wire

// File: testbench/host_model.sv
// Purpose: AHB-Lite host programming the call progress block
// Assumes: one slave, hready taken from its hreadyout
// Notes: released write data is inverted, never left stale
`timescale 1ns/1ps
`default_nettype none
module host_model
  import cp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  logic [31:0] junk;
  initial
  begin
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
  end
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
    hwdata <= ~d;
  endtask
  task start_monitor(input logic [4:0] en);
    xfer(A_SELECT, 1'b1, {24'h0, SEL_TONE}, junk);
    xfer(A_LOW, 1'b1, 32'h0, junk);
    xfer(A_HIGH, 1'b1, {27'h0, en}, junk);
  endtask
  task blind_dial;
    xfer(A_DIALWAIT, 1'b1, 32'h0, junk);
    xfer(A_COMMAND, 1'b1, {29'h0, CMD_DIAL_NUM}, junk);
  endtask
  task connect;
    xfer(A_COMMAND, 1'b1, {29'h0, CMD_DIAL_PLAIN}, junk);
  endtask
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
// Purpose: self-checking bench for call_progress_ctrl
// Assumes: host_model drives the register bus
// Notes: short cadence counts keep the run brief
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import cp_pkg::*;
;
  typedef struct packed {
    logic [4:0]  pres;
    logic [4:0]  en;
    logic [13:0] nrg;
    logic        av;
    logic [7:0]  exp;
  } row_t;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel, hwrite, hreadyout, irq, off_hook, command_mode, answer_search;
  logic        data_avail, dial_done, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize, gen_tone;
  logic [4:0]  class_present;
  logic [7:0]  gen_key;
  logic [10:0] gen_low_hz, gen_high_hz;
  logic [13:0] gen_level, gen_user_freq, filt_data;
  logic [15:0] filt_addr;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [55:0] udf_energy, udf_centers;
  int          errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  row_t rows [8] = '{
    '{5'h1F, 5'h1F, 14'h0, 1'b0, 8'h42}, '{5'h1F, 5'h00, 14'h0, 1'b0, 8'h00},
    '{5'h11, 5'h1F, 14'h0, 1'b0, 8'h45}, '{5'h01, 5'h01, 14'h0, 1'b1, 8'hC1},
    '{5'h0C, 5'h08, 14'h0, 1'b0, 8'h44}, '{5'h1E, 5'h04, 14'h0, 1'b0, 8'h43},
    '{5'h00, 5'h08, 14'h1000, 1'b0, 8'h44}, '{5'h00, 5'h08, 14'h0FFF, 1'b0, 8'h00}};
  string       keys = "0123456789D*#ABC";
  int          lr [16] = '{3, 0, 0, 0, 1, 1, 1, 2, 2, 2, 3, 3, 3, 0, 1, 2};
  int          hc [16] = '{1, 0, 1, 2, 0, 1, 2, 0, 1, 2, 3, 0, 2, 3, 3, 3};
  logic [10:0] lo [4] = '{11'd697, 11'd770, 11'd852, 11'd941};
  logic [10:0] hi [4] = '{11'd1209, 11'd1336, 11'd1477, 11'd1633};
  call_progress_ctrl #(.BUSY_CYC(10), .RING_CYC(20)) i_call_progress_ctrl (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .class_present(class_present), .udf_energy(udf_energy),
    .data_avail(data_avail), .dial_done(dial_done), .irq(irq), .off_hook(off_hook),
    .command_mode(command_mode), .dial_start(), .answer_search(answer_search),
    .gen_tone(gen_tone), .gen_level(gen_level), .gen_user_freq(gen_user_freq),
    .gen_key(gen_key), .gen_low_hz(gen_low_hz), .gen_high_hz(gen_high_hz), .filt_wr(),
    .filt_addr(filt_addr), .filt_data(filt_data), .udf_centers(udf_centers), .busy_tick(),
    .ring_tick());
  host_model i_host_model (
    .clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  always #20 clk = ~clk;
  task close_out;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard, run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      errors++;
      close_out;
    end
  end
  task step(input int n);
    repeat (n) @(posedge clk);
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    i_host_model.xfer(a, 1'b1, d, q);
  endtask
  task rd(input logic [7:0] a);
    i_host_model.xfer(a, 1'b0, 32'h0, q);
  endtask
  task do_reset;
    @(posedge clk);
    rst <= 1'b1;
    step(20);
    chk({irq, off_hook, command_mode, hresp, hreadyout}, 5'b00101);
    chk(udf_centers, {14'd536, 14'd4987, 14'd536, 14'd4987});
    rst <= 1'b0;
    $display("test reset done");
  endtask
  initial
  begin
    class_present = '0;
    udf_energy = '0;
    data_avail = 1'b0;
    dial_done = 1'b0;
    do_reset;
    rd(A_BUSY_CAD);
    chk(q[23:0], 24'h053232);
    rd(A_RING_CAD);
    chk(q[23:0], 24'h084B25);
    wr(A_SELECT, SEL_ADDR);
    wr(A_LOW, 32'h08);
    wr(A_HIGH, 32'h00);
    wr(A_SELECT, SEL_DATA);
    wr(A_HIGH, 32'h01);
    wr(A_LOW, 32'h35);
    step(3);
    chk(udf_centers[27:14], 14'h0135);
    chk({filt_addr, filt_data}, {16'h0008, 14'h0135});
    i_host_model.start_monitor(5'h1F);
    foreach (rows[i])
    begin
      class_present <= rows[i].pres;
      udf_energy <= {42'h0, rows[i].nrg};
      data_avail <= rows[i].av;
      wr(A_HIGH, {27'h0, rows[i].en});
      step(3);
      rd(A_LOW);
      chk(q[7:0], rows[i].exp);
    end
    // events so far are masked
    chk(irq, 1'b0);
    rd(A_IRQ_STAT);
    chk(q[2:0], 3'b101);
    $display("test status done");
    wr(A_LOW, {29'h0, TONE_USER});
    step(3);
    chk({gen_tone, gen_level, gen_user_freq}, {3'h6, 14'd2896, 14'd91});
    for (int c = 0; c < 16; c++)
    begin
      wr(A_LOW, {25'h0, 4'(c), TONE_DTMF});
      step(3);
      chk({gen_key, gen_low_hz, gen_high_hz}, {keys[c], lo[lr[c]], hi[hc[c]]});
    end
    $display("test tones done");
    wr(A_COMMAND, {29'h0, CMD_DIAL_SEMI});
    step(2);
    rd(A_STATE);
    chk({q[1:0], off_hook, command_mode}, 4'b1011);
    // indirect write refused while off-hook
    wr(A_SELECT, SEL_DATA);
    wr(A_LOW, 32'h36);
    step(3);
    chk(udf_centers[27:14], 14'h0135);
    wr(A_COMMAND, {29'h0, CMD_HANGUP});
    wr(A_IRQ_MASK, 32'h2);
    i_host_model.blind_dial;
    step(2);
    rd(A_STATE);
    chk(q[1:0], 2'd1);
    dial_done <= 1'b1;
    step(1);
    dial_done <= 1'b0;
    step(3);
    chk({irq, off_hook, command_mode}, 3'b111);
    rd(A_IRQ_STAT);
    chk(q[2:0], 3'b010);
    step(2);
    chk(irq, 1'b0);
    i_host_model.connect;
    step(2);
    rd(A_STATE);
    chk({q[1:0], answer_search}, 3'b111);
    wr(A_COMMAND, {29'h0, CMD_HANGUP});
    wr(8'h3C, 32'hFFFFFFFF);
    rd(8'h3C);
    chk(q, 32'h0);
    $display("test dial done");
    do_reset;
    close_out;
  end
endmodule
`default_nettype wire
